// file: verilog/fswg_status_guard.sv
`timescale 1ns/1ps
`default_nettype none
module fswg_status_guard #(
	parameter int REGWR_CYCLES = fswg_pkg::REGWR_CYC
) (
	// core clock and reset
	input  wire logic       clk,
	input  wire logic       arst_n,
	// serial link
	input  wire logic       sck,
	input  wire logic       cs_n,
	input  wire logic       mosi,
	output logic            miso_o,
	output logic            miso_oe,
	input  wire logic       wp_n,
	// array engine
	input  wire logic       arr_done,
	input  wire logic       arr_fail,
	input  wire logic       arr_halted,
	input  wire logic       guard_hit,
	input  wire logic       sector_prot,
	input  wire logic       otp_region_locked,
	output logic            arr_prog_go,
	output logic            arr_otp_sel,
	output logic            arr_erase_go,
	output logic            arr_whole_go,
	output logic            arr_pause,
	output logic            arr_abort,
	// register view
	output logic [7:0]      status_one,
	output logic [7:0]      config_one
);

	// ----------------------------------------
	// link domain: shift in opcode and data
	// ----------------------------------------
	logic       link_rst;
	logic [4:0] bit_cnt_reg;
	logic [6:0] in_sh_reg;
	logic [7:0] opc_lk_reg;
	logic [7:0] d1_lk_reg;
	logic [7:0] d2_lk_reg;
	logic [4:0] fbits_lk_reg;
	logic       rd_act_reg;
	logic       rd_stat2_reg;
	logic [7:0] miso_byte;
	logic [7:0] shadow_reg;
	logic [7:0] in_byte;

	// frame end resets the link counters; sck is quiet while cs_n is high
	assign link_rst = cs_n | ~arst_n;
	assign in_byte  = {in_sh_reg, mosi};

	always_ff @(posedge sck or posedge link_rst) begin
		if (link_rst) begin
			bit_cnt_reg <= 5'h00;
		end else if (bit_cnt_reg != fswg_pkg::BITS_SAT) begin
			bit_cnt_reg <= bit_cnt_reg + 5'h01;
		end
	end

	always_ff @(posedge sck or posedge link_rst) begin
		if (link_rst) begin
			rd_act_reg   <= 1'b0;
			rd_stat2_reg <= 1'b0;
		end else if (bit_cnt_reg == 5'h07) begin
			rd_act_reg   <= (in_byte == fswg_pkg::OPC_STATUS_READ) ||
				(in_byte == fswg_pkg::OPC_STATUS2_RD);
			rd_stat2_reg <= (in_byte == fswg_pkg::OPC_STATUS2_RD);
		end
	end

	// capture registers survive the frame end so the core can read them
	always_ff @(posedge sck or negedge arst_n) begin
		if (!arst_n) begin
			in_sh_reg    <= 7'h00;
			opc_lk_reg   <= fswg_pkg::BYTE_RST;
			d1_lk_reg    <= fswg_pkg::BYTE_RST;
			d2_lk_reg    <= fswg_pkg::BYTE_RST;
			fbits_lk_reg <= 5'h00;
		end else begin
			in_sh_reg <= in_byte[6:0];
			if (bit_cnt_reg != fswg_pkg::BITS_SAT) begin
				fbits_lk_reg <= bit_cnt_reg + 5'h01;
			end
			case (bit_cnt_reg)
				5'h07: begin
					opc_lk_reg <= in_byte;
				end
				5'h0F: begin
					d1_lk_reg <= in_byte;
				end
				5'h17: begin
					d2_lk_reg <= in_byte;
				end
				default: begin
				end
			endcase
		end
	end

	// shadow is frozen by the core during a frame, so it is stable here
	assign miso_byte = rd_stat2_reg ? fswg_pkg::BYTE_RST : shadow_reg;

	always_ff @(negedge sck or posedge link_rst) begin
		if (link_rst) begin
			miso_o <= 1'b0;
		end else if (rd_act_reg) begin
			miso_o <= miso_byte[3'h7 - bit_cnt_reg[2:0]];
		end
	end

	assign miso_oe = rd_act_reg;

	// ----------------------------------------
	// core domain: pin synchronisers
	// ----------------------------------------
	logic cs_s1_reg;
	logic cs_s2_reg;
	logic cs_s3_reg;
	logic wp_s1_reg;
	logic wp_s2_reg;
	logic frame_end;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cs_s1_reg <= 1'b1;
			cs_s2_reg <= 1'b1;
			cs_s3_reg <= 1'b1;
			wp_s1_reg <= 1'b1;
			wp_s2_reg <= 1'b1;
		end else begin
			cs_s1_reg <= cs_n;
			cs_s2_reg <= cs_s1_reg;
			cs_s3_reg <= cs_s2_reg;
			wp_s1_reg <= wp_n;
			wp_s2_reg <= wp_s1_reg;
		end
	end

	// link captures are read only here, two clocks after cs_n rose
	assign frame_end = cs_s2_reg & ~cs_s3_reg;

	// ----------------------------------------
	// command decode
	// ----------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE, ST_REGWR, ST_PROG, ST_ERASE, ST_WHOLE, ST_HALT, ST_FAULT
	} fswg_state_t;

	fswg_state_t state_reg;
	logic        lock_nv_reg;
	logic [2:0]  guard_nv_reg;
	logic [2:0]  guard_vol_reg;
	logic        volsel_reg;
	logic        cfg_lock_reg;
	logic        pflt_reg;
	logic        eflt_reg;
	logic        latch_reg;
	logic [2:0]  guard;
	logic        hw_prot;
	logic        byte_ok;
	logic        go;
	logic        idle;
	logic        is_srst;
	logic        is_clear_status_cmd;
	logic        wr_ok;
	logic        wr_cfg;
	logic        prog_go;
	logic        prog_bad;
	logic        otp_bad;
	logic        erase_go;
	logic        erase_bad;
	logic        whole_go;
	logic        pause_go;
	logic        op_end_ok;
	logic        op_end_bad;
	logic        regwr_end;
	logic [15:0] timer_reg;

	assign guard   = volsel_reg ? guard_vol_reg : guard_nv_reg;
	assign hw_prot = lock_nv_reg & ~wp_s2_reg;
	assign byte_ok = (fbits_lk_reg >= fswg_pkg::BITS_ONE_BYTE) &&
		(fbits_lk_reg[2:0] == 3'h0);
	assign go      = frame_end & byte_ok;
	assign idle    = (state_reg == ST_IDLE);
	assign is_srst = go && (opc_lk_reg == fswg_pkg::OPC_SOFT_RESET);
	assign is_clear_status_cmd = go && (opc_lk_reg == fswg_pkg::OPC_CLEAR_STAT);

	// new operations only from idle with the latch armed
	assign wr_ok = go && idle && latch_reg && !hw_prot &&
		(opc_lk_reg == fswg_pkg::OPC_REG_WRITE) &&
		(fbits_lk_reg >= fswg_pkg::BITS_TWO_BYTE);
	assign wr_cfg = wr_ok && (fbits_lk_reg >= fswg_pkg::BITS_THR_BYTE);

	assign otp_bad  = cfg_lock_reg | otp_region_locked;
	assign prog_go  = go && idle && latch_reg &&
		((opc_lk_reg == fswg_pkg::OPC_PROGRAM) ||
		(opc_lk_reg == fswg_pkg::OPC_OTP_PROGRAM));
	assign prog_bad = (opc_lk_reg == fswg_pkg::OPC_OTP_PROGRAM) ? otp_bad :
		((guard != 3'h0) & guard_hit) | sector_prot;
	assign erase_go = go && idle && latch_reg &&
		(opc_lk_reg == fswg_pkg::OPC_SECT_ERASE);
	assign erase_bad = ((guard != 3'h0) & guard_hit) | sector_prot;
	assign whole_go = go && idle && latch_reg && (guard == 3'h0) &&
		(opc_lk_reg == fswg_pkg::OPC_WHOLE_ERASE);
	assign pause_go = go &&
		(((opc_lk_reg == fswg_pkg::OPC_PROG_PAUSE) && (state_reg == ST_PROG)) ||
		((opc_lk_reg == fswg_pkg::OPC_ERASE_PAUSE) && (state_reg == ST_ERASE)));

	assign op_end_ok  = arr_done && !arr_fail &&
		((state_reg == ST_PROG) || (state_reg == ST_ERASE) || (state_reg == ST_WHOLE));
	assign op_end_bad = arr_done && arr_fail &&
		((state_reg == ST_PROG) || (state_reg == ST_ERASE) || (state_reg == ST_WHOLE));
	assign regwr_end  = (state_reg == ST_REGWR) && (timer_reg == 16'h0000);

	// ----------------------------------------
	// operation sequencer
	// ----------------------------------------
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state_reg <= ST_IDLE;
		end else if (is_srst) begin
			state_reg <= ST_IDLE;
		end else begin
			case (state_reg)
				ST_IDLE: begin
					if (wr_ok) begin
						state_reg <= ST_REGWR;
					end else if (prog_go) begin
						state_reg <= prog_bad ? ST_FAULT : ST_PROG;
					end else if (erase_go) begin
						state_reg <= erase_bad ? ST_FAULT : ST_ERASE;
					end else if (whole_go) begin
						state_reg <= ST_WHOLE;
					end
				end
				ST_REGWR: begin
					if (regwr_end) begin
						state_reg <= ST_IDLE;
					end
				end
				ST_PROG, ST_ERASE, ST_WHOLE: begin
					if (op_end_bad) begin
						state_reg <= ST_FAULT;
					end else if (op_end_ok) begin
						state_reg <= ST_IDLE;
					end else if (pause_go) begin
						state_reg <= ST_HALT;
					end
				end
				ST_HALT: begin
					if (arr_halted) begin
						state_reg <= ST_IDLE;
					end
				end
				ST_FAULT: begin
					if (is_clear_status_cmd) begin
						state_reg <= ST_IDLE;
					end
				end
				default: begin
					state_reg <= ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			timer_reg <= 16'h0000;
		end else if (wr_ok) begin
			timer_reg <= 16'(REGWR_CYCLES - 1);
		end else if (timer_reg != 16'h0000) begin
			timer_reg <= timer_reg - 16'h0001;
		end
	end

	// ----------------------------------------
	// write latch
	// ----------------------------------------
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			latch_reg <= 1'b0;
		end else if (is_srst) begin
			latch_reg <= 1'b0;
		end else if (op_end_ok || regwr_end) begin
			latch_reg <= 1'b0;
		end else if (go && idle && (opc_lk_reg == fswg_pkg::OPC_ARM)) begin
			latch_reg <= 1'b1;
		end else if (go && idle && (opc_lk_reg == fswg_pkg::OPC_DISARM)) begin
			latch_reg <= 1'b0;
		end
	end

	// ----------------------------------------
	// fault flags: a set in the clear cycle wins
	// ----------------------------------------
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			pflt_reg <= 1'b0;
		end else if ((prog_go && prog_bad) || (op_end_bad && state_reg == ST_PROG)) begin
			pflt_reg <= 1'b1;
		end else if (is_clear_status_cmd || is_srst) begin
			pflt_reg <= 1'b0;
		end
	end

	// whole array erase reports only a real array failure
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			eflt_reg <= 1'b0;
		end else if ((erase_go && erase_bad) ||
			(op_end_bad && state_reg != ST_PROG)) begin
			eflt_reg <= 1'b1;
		end else if (is_clear_status_cmd || is_srst) begin
			eflt_reg <= 1'b0;
		end
	end

	// ----------------------------------------
	// lock, guard and config bits
	// ----------------------------------------
	// non-volatile copies change only on power-up reset or a register write; soft reset keeps them
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			lock_nv_reg  <= 1'b0;
			guard_nv_reg <= fswg_pkg::GUARD_NV_RST;
		end else if (wr_ok) begin
			lock_nv_reg <= d1_lk_reg[fswg_pkg::ST_LOCK_BIT];
			if (!cfg_lock_reg && !volsel_reg) begin
				guard_nv_reg <= d1_lk_reg[fswg_pkg::ST_GUARD_HI:fswg_pkg::ST_GUARD_LO];
			end
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			guard_vol_reg <= fswg_pkg::GUARD_VOL_RST;
		end else if (is_srst) begin
			guard_vol_reg <= fswg_pkg::GUARD_VOL_RST;
		end else if (wr_ok && !cfg_lock_reg && volsel_reg) begin
			guard_vol_reg <= d1_lk_reg[fswg_pkg::ST_GUARD_HI:fswg_pkg::ST_GUARD_LO];
		end
	end

	// volatility select is one-time settable; the config lock sets until reset
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			volsel_reg <= 1'b0;
		end else if (wr_cfg && !cfg_lock_reg && d2_lk_reg[fswg_pkg::CF_VOLSEL_BIT]) begin
			volsel_reg <= 1'b1;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cfg_lock_reg <= 1'b0;
		end else if (is_srst) begin
			cfg_lock_reg <= 1'b0;
		end else if (wr_cfg && d2_lk_reg[fswg_pkg::CF_LOCK_BIT]) begin
			cfg_lock_reg <= 1'b1;
		end
	end

	// ----------------------------------------
	// array engine strobes
	// ----------------------------------------
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			arr_prog_go  <= 1'b0;
			arr_otp_sel  <= 1'b0;
			arr_erase_go <= 1'b0;
			arr_whole_go <= 1'b0;
			arr_pause    <= 1'b0;
			arr_abort    <= 1'b0;
		end else begin
			arr_prog_go  <= prog_go && !prog_bad;
			arr_erase_go <= erase_go && !erase_bad;
			arr_whole_go <= whole_go;
			arr_pause    <= pause_go && !is_srst;
			arr_abort    <= is_srst && !idle && (state_reg != ST_REGWR);
			if (prog_go) begin
				arr_otp_sel <= (opc_lk_reg == fswg_pkg::OPC_OTP_PROGRAM);
			end
		end
	end

	// ----------------------------------------
	// status view
	// ----------------------------------------
	always_comb begin
		status_one = fswg_pkg::BYTE_RST;
		status_one[fswg_pkg::ST_LOCK_BIT]  = lock_nv_reg;
		status_one[fswg_pkg::ST_PFLT_BIT]  = pflt_reg;
		status_one[fswg_pkg::ST_EFLT_BIT]  = eflt_reg;
		status_one[fswg_pkg::ST_GUARD_HI:fswg_pkg::ST_GUARD_LO] = guard;
		status_one[fswg_pkg::ST_LATCH_BIT] = latch_reg;
		status_one[fswg_pkg::ST_BUSY_BIT]  = !idle;
	end

	always_comb begin
		config_one = fswg_pkg::BYTE_RST;
		config_one[fswg_pkg::CF_VOLSEL_BIT] = volsel_reg;
		config_one[fswg_pkg::CF_LOCK_BIT]   = cfg_lock_reg;
	end

	// shadow follows only between frames; a poll that spans a change
	// shows the older value and the host simply reads again
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			shadow_reg <= fswg_pkg::BYTE_RST;
		end else if (cs_s2_reg) begin
			shadow_reg <= status_one;
		end
	end

endmodule
`default_nettype wire

// file: verilog/fswg_pkg.sv
// Summary of operation
// - lock bit set and guard pin low: register writes ignored, lock and guard frozen
// - lock clear or guard pin high: register write may change lock and guard bits
// - failed program, or program into protected sector or locked otp, sets program fault
// - failed erase, or erase of a protected sector, sets erase fault
// - whole array erase meeting protected sectors does not set erase fault
// - fault flags read-only; only clear status or a reset returns them to zero
// - guard bits volatile when volatility select is one, then reset to ones
// - any guard bit set rejects program and erase into the guarded area
// - whole array erase runs only while all guard bits are zero
// - arm write command sets the write latch
// - disarm write command clears the write latch
// - latch clear: register write, program and erase commands are ignored
// - successful program, register write or erase clears the write latch
// - latch zero after any reset; register write data never sets it
// - busy bit reads one while any internal operation runs, zero when idle
// - while busy only reads, pauses, clear status and soft reset are taken
// - pause commands taken only while the matching array operation runs
// - faults keep busy set until a clear status or soft reset command arrives
// - opcodes: read 05h, write 01h, arm 06h, disarm 04h, clear 30h
// - config lock holds guard bits and blocks otp programming until reset
package fswg_pkg;

	// ----------------------------------------
	// command opcodes
	// ----------------------------------------
	localparam logic [7:0] OPC_REG_WRITE   = 8'h01;
	localparam logic [7:0] OPC_PROGRAM     = 8'h02;
	localparam logic [7:0] OPC_DISARM      = 8'h04;
	localparam logic [7:0] OPC_STATUS_READ = 8'h05;
	localparam logic [7:0] OPC_ARM         = 8'h06;
	localparam logic [7:0] OPC_STATUS2_RD  = 8'h07;
	localparam logic [7:0] OPC_CLEAR_STAT  = 8'h30;
	localparam logic [7:0] OPC_OTP_PROGRAM = 8'h42;
	localparam logic [7:0] OPC_ERASE_PAUSE = 8'h75;
	localparam logic [7:0] OPC_PROG_PAUSE  = 8'h85;
	localparam logic [7:0] OPC_WHOLE_ERASE = 8'hC7;
	localparam logic [7:0] OPC_SECT_ERASE  = 8'hD8;
	localparam logic [7:0] OPC_SOFT_RESET  = 8'hF0;

	// ----------------------------------------
	// status_one field positions
	// ----------------------------------------
	localparam int ST_LOCK_BIT  = 7;
	localparam int ST_PFLT_BIT  = 6;
	localparam int ST_EFLT_BIT  = 5;
	localparam int ST_GUARD_HI  = 4;
	localparam int ST_GUARD_LO  = 2;
	localparam int ST_LATCH_BIT = 1;
	localparam int ST_BUSY_BIT  = 0;

	// ----------------------------------------
	// config_one field positions
	// ----------------------------------------
	localparam int CF_VOLSEL_BIT = 3;
	localparam int CF_LOCK_BIT   = 0;

	// ----------------------------------------
	// reset values
	// ----------------------------------------
	localparam logic [2:0] GUARD_VOL_RST = 3'h7;
	localparam logic [2:0] GUARD_NV_RST  = 3'h0;
	localparam logic [7:0] BYTE_RST      = 8'h00;

	// ----------------------------------------
	// frame lengths in link clock edges
	// ----------------------------------------
	localparam logic [4:0] BITS_ONE_BYTE = 5'h08;
	localparam logic [4:0] BITS_TWO_BYTE = 5'h10;
	localparam logic [4:0] BITS_THR_BYTE = 5'h18;
	localparam logic [4:0] BITS_SAT      = 5'h1F;

	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int CLK_MHZ       = 125;
	localparam int REGWR_TIME_NS = 500;
	localparam int REGWR_CYC     = (REGWR_TIME_NS * CLK_MHZ + 999) / 1000;

endpackage

// file: test/fswg_status_guard_chk.sv
`timescale 1ns/1ps
`default_nettype none
module fswg_status_guard_chk (
	// clock and reset
	input wire logic       clk,
	input wire logic       arst_n,
	// pins
	input wire logic       cs_n,
	input wire logic       wp_n,
	input wire logic       miso_oe,
	// array engine
	input wire logic       arr_done,
	input wire logic       arr_fail,
	input wire logic       guard_hit,
	input wire logic       arr_prog_go,
	input wire logic       arr_otp_sel,
	input wire logic       arr_erase_go,
	input wire logic       arr_whole_go,
	input wire logic       arr_pause,
	// register view
	input wire logic [7:0] status_one,
	input wire logic [7:0] config_one
);
	logic [2:0] guard;
	logic       flt;
	assign guard = status_one[4:2];
	assign flt = status_one[6] | status_one[5];
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	// ----------------------------------------
	// sequences
	// ----------------------------------------
	// four low samples cover the two-flop pin synchroniser
	sequence hw_locked_s;
		(!wp_n)[*4] ##0 status_one[7] && !config_one[3];
	endsequence
	sequence clean_done_s;
		arr_done && !arr_fail && status_one[0] && !flt;
	endsequence
	// ----------------------------------------
	// assertions
	// ----------------------------------------
	AST_HW_FREEZE: assert property (hw_locked_s |=> $stable({status_one[7], guard}))
		else $error("lock or guard changed under hardware protection");
	AST_GO_NEEDS_LATCH: assert property ((arr_prog_go || arr_erase_go || arr_whole_go)
		|-> status_one[1] && status_one[0] && !$past(status_one[0]))
		else $error("array start without latch or while busy");
	AST_WHOLE_GUARD: assert property (arr_whole_go |-> guard == 3'h0)
		else $error("whole erase started with guard bits set");
	AST_GUARD_BLOCKS: assert property (((arr_prog_go && !arr_otp_sel) || arr_erase_go)
		|-> !($past(guard_hit) && $past(guard) != 3'h0))
		else $error("array start inside guarded area");
	AST_FAULT_BUSY: assert property (flt |-> status_one[0])
		else $error("fault flag set without busy");
	AST_FAULT_CLEAR: assert property (($fell(status_one[6]) || $fell(status_one[5]))
		|-> $fell(status_one[0]))
		else $error("fault cleared apart from return to standby");
	AST_PAUSE_BUSY: assert property (arr_pause |-> $past(status_one[0]) && !$past(flt))
		else $error("pause issued with no array operation running");
	AST_LATCH_DONE: assert property (clean_done_s |=> status_one[1:0] == 2'h0)
		else $error("latch or busy left set after good completion");
	AST_READ_QUIET: assert property (cs_n |-> !miso_oe)
		else $error("data out enabled outside a frame");
endmodule
bind fswg_status_guard fswg_status_guard_chk chk (.clk(clk), .arst_n(arst_n), .cs_n(cs_n),
	.wp_n(wp_n), .miso_oe(miso_oe), .arr_done(arr_done), .arr_fail(arr_fail),
	.guard_hit(guard_hit), .arr_prog_go(arr_prog_go), .arr_otp_sel(arr_otp_sel),
	.arr_erase_go(arr_erase_go), .arr_whole_go(arr_whole_go), .arr_pause(arr_pause),
	.status_one(status_one), .config_one(config_one));
`default_nettype wire

// file: test/fswg_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module fswg_host_model (
	// serial link
	output logic      sck,
	output logic      cs_n,
	output logic      mosi,
	input wire logic  miso_o,
	input wire logic  miso_oe
);
	initial begin
		sck = 1'b0;
		cs_n = 1'b1;
		mosi = 1'b1;
	end
	// mode 0, 12 ns link clock, only toggling inside a frame; the 1 ns lead keeps
	// every link edge off the core clock edges
	task automatic xfer(input logic [23:0] tx, input int nbits, output logic [7:0] rx);
		rx = 8'h00;
		#1;
		cs_n = 1'b0;
		for (int i = 0; i < nbits; i++) begin
			mosi = tx[23 - i];
			#6;
			sck = 1'b1;
			if (i >= 8 && i < 16)
				rx = {rx[6:0], (miso_oe === 1'b1) ? miso_o : 1'bx};
			#6;
			sck = 1'b0;
		end
		#6;
		cs_n = 1'b1;
		// released line shows no stale data
		mosi = ~mosi;
	endtask
endmodule
`default_nettype wire

// file: test/flash_status_write_guard_test.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin samples_checked++; if ((got) !== (exp)) begin miscompares++; \
	$display("BAD %s expected %h seen %h", nm, exp, got); end end
module flash_status_write_guard_test;
	logic clk, arst_n, sck, cs_n, mosi, miso_o, miso_oe, wp_n;
	logic arr_done, arr_fail, arr_halted, guard_hit, sector_prot, otp_region_locked;
	logic arr_prog_go, arr_otp_sel, arr_erase_go, arr_whole_go, arr_pause, arr_abort;
	logic [7:0] status_one, config_one;
	int miscompares, samples_checked, n_prog, n_erase, n_whole, n_pause, n_abort;

	fswg_status_guard #(.REGWR_CYCLES(2)) uut (.clk(clk), .arst_n(arst_n), .sck(sck),
		.cs_n(cs_n), .mosi(mosi), .miso_o(miso_o), .miso_oe(miso_oe), .wp_n(wp_n),
		.arr_done(arr_done), .arr_fail(arr_fail), .arr_halted(arr_halted),
		.guard_hit(guard_hit), .sector_prot(sector_prot),
		.otp_region_locked(otp_region_locked), .arr_prog_go(arr_prog_go),
		.arr_otp_sel(arr_otp_sel), .arr_erase_go(arr_erase_go), .arr_whole_go(arr_whole_go),
		.arr_pause(arr_pause), .arr_abort(arr_abort), .status_one(status_one),
		.config_one(config_one));
	fswg_host_model host (.sck(sck), .cs_n(cs_n), .mosi(mosi), .miso_o(miso_o),
		.miso_oe(miso_oe));

	always #4 clk = ~clk;
	always @(posedge clk) begin
		n_prog += (arr_prog_go === 1'b1);
		n_erase += (arr_erase_go === 1'b1);
		n_whole += (arr_whole_go === 1'b1);
		n_pause += (arr_pause === 1'b1);
		n_abort += (arr_abort === 1'b1);
	end
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic send(input logic [23:0] tx, input int nb);
		logic [7:0] rx;
		host.xfer(tx, nb, rx);
		repeat (10) @(negedge clk);
	endtask
	task automatic expect_st(input string nm, input logic [7:0] exp);
		logic [7:0] rx;
		`CHK(nm, exp, status_one)
		host.xfer(24'h050000, 16, rx);
		repeat (6) @(negedge clk);
		`CHK(nm, exp, rx)
	endtask
	task automatic array_end(input logic fail, input logic halt);
		@(negedge clk);
		arr_done = !halt;
		arr_fail = fail;
		arr_halted = halt;
		@(negedge clk);
		{arr_done, arr_fail, arr_halted} = 3'h0;
		repeat (3) @(negedge clk);
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_latch();
		`CHK("status reset", 8'h00, status_one)
		`CHK("config reset", 8'h00, config_one)
		send(24'h019C00, 16);
		expect_st("write disarmed", 8'h00);
		send(24'h060000, 8);
		expect_st("arm", 8'h02);
		send(24'h040000, 8);
		expect_st("disarm", 8'h00);
		send(24'h060000, 8);
		send(24'h01FC00, 16);
		expect_st("reg write", 8'h9C);
		$display("latch test done");
	endtask
	task automatic t_hw_protect();
		@(negedge clk) wp_n = 1'b0;
		send(24'h060000, 8);
		send(24'h010000, 16);
		expect_st("hw protected", 8'h9E);
		@(negedge clk) wp_n = 1'b1;
		send(24'h010000, 16);
		expect_st("pin high", 8'h00);
		$display("protect test done");
	endtask
	task automatic t_whole_erase();
		int w, p, a;
		w = n_whole;
		p = n_pause;
		a = n_abort;
		@(negedge clk) sector_prot = 1'b1;
		send(24'h060000, 8);
		send(24'hC70000, 8);
		`CHK("whole start", w + 1, n_whole)
		expect_st("whole busy", 8'h03);
		send(24'h040000, 8);
		expect_st("busy ignores", 8'h03);
		send(24'h850000, 8);
		`CHK("wrong pause", p, n_pause)
		send(24'h750000, 8);
		`CHK("whole no pause", p, n_pause)
		array_end(1'b0, 1'b0);
		expect_st("whole done", 8'h00);
		@(negedge clk) sector_prot = 1'b0;
		send(24'h060000, 8);
		send(24'hD80000, 8);
		send(24'h750000, 8);
		`CHK("erase pause", p + 1, n_pause)
		array_end(1'b0, 1'b1);
		expect_st("paused", 8'h02);
		send(24'hC70000, 8);
		array_end(1'b0, 1'b0);
		`CHK("whole again", w + 2, n_whole)
		expect_st("whole again done", 8'h00);
		send(24'h060000, 8);
		send(24'hD80000, 8);
		send(24'hF00000, 8);
		`CHK("abort on reset", a + 1, n_abort)
		expect_st("reset mid erase", 8'h00);
		$display("whole erase test done");
	endtask
	task automatic t_prog_fail();
		int g, w;
		g = n_prog;
		w = n_whole;
		send(24'h060000, 8);
		send(24'h020000, 8);
		`CHK("program start", g + 1, n_prog)
		array_end(1'b1, 1'b0);
		expect_st("program fail", 8'h43);
		send(24'hC70000, 8);
		`CHK("busy no erase", w, n_whole)
		send(24'h300000, 8);
		expect_st("clear status", 8'h02);
		send(24'h040000, 8);
		expect_st("disarm after fail", 8'h00);
		$display("program fail test done");
	endtask
	task automatic t_guarded();
		int g, e, w;
		send(24'h060000, 8);
		send(24'h010400, 16);
		expect_st("guard set", 8'h04);
		g = n_prog;
		e = n_erase;
		w = n_whole;
		@(negedge clk) guard_hit = 1'b1;
		send(24'h060000, 8);
		send(24'h020000, 8);
		`CHK("guarded program", g, n_prog)
		expect_st("program refused", 8'h47);
		send(24'h300000, 8);
		@(negedge clk) {guard_hit, sector_prot} = 2'h1;
		send(24'hD80000, 8);
		`CHK("protected erase", e, n_erase)
		expect_st("erase refused", 8'h27);
		send(24'h300000, 8);
		send(24'hC70000, 8);
		`CHK("guarded whole", w, n_whole)
		expect_st("whole refused", 8'h06);
		@(negedge clk) sector_prot = 1'b0;
		send(24'h010000, 16);
		expect_st("guard cleared", 8'h00);
		$display("guard test done");
	endtask
	task automatic t_volatile();
		send(24'h060000, 8);
		send(24'h010008, 24);
		`CHK("volatile select", 8'h08, config_one)
		send(24'hF00000, 8);
		expect_st("volatile default", 8'h1C);
		send(24'h060000, 8);
		send(24'h011C09, 24);
		`CHK("config lock", 8'h09, config_one)
		send(24'h060000, 8);
		send(24'h420000, 8);
		expect_st("otp refused", 8'h5F);
		send(24'hF00000, 8);
		`CHK("soft reset config", 8'h08, config_one)
		expect_st("soft reset", 8'h1C);
		$display("volatile test done");
	endtask
	// ----------------------------------------
	// run control
	// ----------------------------------------
	task automatic complete_run();
		$display("checks %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	initial begin
		#300000;
		miscompares++;
		complete_run();
	end
	initial begin
		{clk, arst_n, arr_done, arr_fail, arr_halted} = 5'h00;
		{guard_hit, sector_prot, otp_region_locked} = 3'h0;
		wp_n = 1'b1;
		repeat (12) @(negedge clk);
		arst_n = 1'b1;
		repeat (4) @(negedge clk);
		t_latch();
		t_hw_protect();
		t_whole_erase();
		t_prog_fail();
		t_guarded();
		t_volatile();
		complete_run();
	end
endmodule
`default_nettype wire
